// [sbst_consts.vh]
// Constants for the SRAM boundary-scan test access port.
// Included by bare name; holds definitions only.
`ifndef SBST_CONSTS_VH
`define SBST_CONSTS_VH

// Instruction register
`define SBST_IR_W          3
`define SBST_IR_EXTEST     3'h0
`define SBST_IR_IDCODE     3'h1
`define SBST_IR_SAMPLE_Z   3'h2
`define SBST_IR_SAMPLE     3'h4
`define SBST_IR_BYPASS     3'h7
`define SBST_IR_CAPTURE    3'h1

// Identification register; code value is arbitrary
`define SBST_ID_W          32
`define SBST_ID_VALUE      32'h0A5C_3001

// Boundary scan register
`define SBST_BSR_LEN       16
`define SBST_BSR_HIZ_CELL  15
`define SBST_BSR_PRESET    16'h8000
`define SBST_BSR_ZERO      16'h0000

// Synchroniser idle levels
`define SBST_PULL_HIGH     1'b1
`define SBST_TCK_IDLE      1'b0

// Serial output enable levels and cleared bit level
`define SBST_OE_OFF        1'h1
`define SBST_OE_ON         1'h0
`define SBST_BIT_LOW       1'h0

`endif

// [sbst_bsr.v]
// Boundary scan register: capture, shift and update-latched preload stage.
// Assumes capture, shift and update are one-cycle strokes from the TAP on SYS_CLK_I.
`timescale 1ns/10ps
`include "sbst_consts.vh"

module sbst_bsr (
	input  wire                      clk_i,
	input  wire                      rst_i,
	input  wire                      tlr_i,
	input  wire                      capture_i,
	input  wire                      shift_i,
	input  wire                      update_i,
	input  wire                      tdi_i,
	input  wire [`SBST_BSR_LEN-1:0]  ring_i,
	output wire                      so_o,
	output reg  [`SBST_BSR_LEN-1:0]  preload_o
);

	reg [`SBST_BSR_LEN-1:0] shift_q;

	assign so_o = shift_q[0];

	// ***************************************************************
	// Capture and shift stage
	// ***************************************************************
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_q <= `SBST_BSR_ZERO;
		end else if (capture_i) begin
			shift_q <= ring_i;
		end else if (shift_i) begin
			shift_q <= {tdi_i, shift_q[`SBST_BSR_LEN-1:1]};
		end
	end

	// ***************************************************************
	// Preload stage
	// ***************************************************************
	// Output-bus enable cell comes up high so outputs are enabled
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			preload_o <= `SBST_BSR_PRESET;
		end else if (tlr_i) begin
			preload_o <= `SBST_BSR_PRESET;
		end else if (update_i) begin
			preload_o <= shift_q;
		end
	end

endmodule // sbst_bsr

// [sbst_tap.v]
// Boundary-scan test access port of a synchronous pipelined SRAM.
// Assumes SYS_CLK_I is much faster than TCK; TCK, TMS, TDI and RING_I come
// from outside this clock domain. Pull-ups sit at the pads outside this logic.
//
// Operation
// - Test port works only from test clock: sample on rise, drive on fall.
// - Test clock drives only the TAP, never the memory datapath.
// - Mode-select and serial input read high when left unconnected.
// - Serial input enters the MSB of the selected register.
// - Serial output comes from the selected LSB, changing on falling edges.
// - Output driver enabled by controller state, high impedance otherwise.
// - Instruction selects exactly one register into the serial path.
// - Five rising edges with mode-select high reach reset from any state.
// - Test-port reset leaves memory accesses untouched.
// - Power-up reset puts controller in reset, output off, no clock needed.
// - Instruction register is three bits, loaded serially in its scan path.
// - Instruction register holds identification after power-up and reset.
// - Instruction capture loads binary 01 into the two low bits.
// - Bypass register is one bit, single stage from input to output.
// - Bypass register clears low when bypass instruction takes effect.
// - Boundary register has one cell per input and bidirectional ball.
// - Boundary register captures ring in capture state, shifts afterwards.
// - External-test, sample/preload and outputs-off select boundary register.
// - Identification instruction captures fixed 32-bit code, then shifts it.
// - New instruction takes effect only in instruction-update state.
// - Outputs-off instruction floats memory output bus until next update.
// - External-test drives preloaded cell values onto system outputs.
`timescale 1ns/10ps
`include "sbst_consts.vh"

module sbst_tap (
	input  wire                      SYS_CLK_I,
	input  wire                      RESET_I,
	input  wire                      TCK_I,
	input  wire                      TMS_I,
	input  wire                      TDI_I,
	input  wire [`SBST_BSR_LEN-1:0]  RING_I,
	output reg                       TDO_O,
	output reg                       TDO_OE_N_O,
	output wire [`SBST_BSR_LEN-1:0]  RING_DRIVE_O,
	output reg                       EXTEST_O,
	output reg                       Q_BUS_HIZ_O
);

	// ***************************************************************
	// Controller states
	// ***************************************************************
	localparam [15:0] ST_TLR   = 16'h0001;
	localparam [15:0] ST_RTI   = 16'h0002;
	localparam [15:0] ST_SELDR = 16'h0004;
	localparam [15:0] ST_CAPDR = 16'h0008;
	localparam [15:0] ST_SHDR  = 16'h0010;
	localparam [15:0] ST_EX1DR = 16'h0020;
	localparam [15:0] ST_PSDR  = 16'h0040;
	localparam [15:0] ST_EX2DR = 16'h0080;
	localparam [15:0] ST_UPDR  = 16'h0100;
	localparam [15:0] ST_SELIR = 16'h0200;
	localparam [15:0] ST_CAPIR = 16'h0400;
	localparam [15:0] ST_SHIR  = 16'h0800;
	localparam [15:0] ST_EX1IR = 16'h1000;
	localparam [15:0] ST_PSIR  = 16'h2000;
	localparam [15:0] ST_EX2IR = 16'h4000;
	localparam [15:0] ST_UPIR  = 16'h8000;

	// ***************************************************************
	// Functions
	// ***************************************************************
	function [15:0] next_state;
		input [15:0] st;
		input        tms;
		begin
			case (st)
				ST_TLR:   next_state = tms ? ST_TLR   : ST_RTI;
				ST_RTI:   next_state = tms ? ST_SELDR : ST_RTI;
				ST_SELDR: next_state = tms ? ST_SELIR : ST_CAPDR;
				ST_CAPDR: next_state = tms ? ST_EX1DR : ST_SHDR;
				ST_SHDR:  next_state = tms ? ST_EX1DR : ST_SHDR;
				ST_EX1DR: next_state = tms ? ST_UPDR  : ST_PSDR;
				ST_PSDR:  next_state = tms ? ST_EX2DR : ST_PSDR;
				ST_EX2DR: next_state = tms ? ST_UPDR  : ST_SHDR;
				ST_UPDR:  next_state = tms ? ST_SELDR : ST_RTI;
				ST_SELIR: next_state = tms ? ST_TLR   : ST_CAPIR;
				ST_CAPIR: next_state = tms ? ST_EX1IR : ST_SHIR;
				ST_SHIR:  next_state = tms ? ST_EX1IR : ST_SHIR;
				ST_EX1IR: next_state = tms ? ST_UPIR  : ST_PSIR;
				ST_PSIR:  next_state = tms ? ST_EX2IR : ST_PSIR;
				ST_EX2IR: next_state = tms ? ST_UPIR  : ST_SHIR;
				ST_UPIR:  next_state = tms ? ST_SELDR : ST_RTI;
				default:  next_state = ST_TLR;
			endcase
		end
	endfunction

	// Boundary register is the data path for these instructions
	function sel_bsr;
		input [`SBST_IR_W-1:0] ir;
		begin
			sel_bsr = (ir == `SBST_IR_EXTEST) || (ir == `SBST_IR_SAMPLE) ||
				(ir == `SBST_IR_SAMPLE_Z);
		end
	endfunction

	function sel_id;
		input [`SBST_IR_W-1:0] ir;
		begin
			sel_id = (ir == `SBST_IR_IDCODE);
		end
	endfunction

	// ***************************************************************
	// Input synchronisers
	// ***************************************************************
	reg                      tck_s1_q;
	reg                      tck_s2_q;
	reg                      tck_s3_q;
	reg                      tms_s1_q;
	reg                      tms_s2_q;
	reg                      tdi_s1_q;
	reg                      tdi_s2_q;
	reg [`SBST_BSR_LEN-1:0]  ring_s1_q;
	reg [`SBST_BSR_LEN-1:0]  ring_s2_q;

	// Idle-high levels keep an unused port parked in reset
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tck_s1_q <= `SBST_TCK_IDLE;
			tck_s2_q <= `SBST_TCK_IDLE;
			tck_s3_q <= `SBST_TCK_IDLE;
			tms_s1_q <= `SBST_PULL_HIGH;
			tms_s2_q <= `SBST_PULL_HIGH;
			tdi_s1_q <= `SBST_PULL_HIGH;
			tdi_s2_q <= `SBST_PULL_HIGH;
			ring_s1_q <= `SBST_BSR_ZERO;
			ring_s2_q <= `SBST_BSR_ZERO;
		end else begin
			tck_s1_q <= TCK_I;
			tck_s2_q <= tck_s1_q;
			tck_s3_q <= tck_s2_q;
			tms_s1_q <= TMS_I;
			tms_s2_q <= tms_s1_q;
			tdi_s1_q <= TDI_I;
			tdi_s2_q <= tdi_s1_q;
			ring_s1_q <= RING_I;
			ring_s2_q <= ring_s1_q;
		end
	end

	// Test clock is only sampled here; no memory logic sees it
	wire tck_rise = tck_s2_q & ~tck_s3_q;
	wire tck_fall = ~tck_s2_q & tck_s3_q;

	// ***************************************************************
	// Controller
	// ***************************************************************
	reg [15:0] state_q;
	reg [15:0] state_d;

	always @* begin
		state_d = state_q;
		if (tck_rise) begin
			state_d = next_state(state_q, tms_s2_q);
		end
	end

	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			state_q <= ST_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	wire in_tlr   = (state_q == ST_TLR);
	wire cap_ir   = tck_rise && (state_q == ST_CAPIR);
	wire shift_ir = tck_rise && (state_q == ST_SHIR);
	wire upd_ir   = tck_rise && (state_q == ST_UPIR);
	wire cap_dr   = tck_rise && (state_q == ST_CAPDR);
	wire shift_dr = tck_rise && (state_q == ST_SHDR);
	wire upd_dr   = tck_rise && (state_q == ST_UPDR);

	// ***************************************************************
	// Instruction register
	// ***************************************************************
	reg [`SBST_IR_W-1:0] ir_sh_q;
	reg [`SBST_IR_W-1:0] ir_q;

	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ir_sh_q <= `SBST_IR_CAPTURE;
			ir_q    <= `SBST_IR_IDCODE;
		end else if (in_tlr) begin
			ir_sh_q <= `SBST_IR_CAPTURE;
			ir_q    <= `SBST_IR_IDCODE;
		end else begin
			if (cap_ir) begin
				ir_sh_q <= `SBST_IR_CAPTURE;
			end else if (shift_ir) begin
				ir_sh_q <= {tdi_s2_q, ir_sh_q[`SBST_IR_W-1:1]};
			end
			if (upd_ir) begin
				ir_q <= ir_sh_q;
			end
		end
	end

	wire path_bsr = sel_bsr(ir_q);
	wire path_id  = sel_id(ir_q);

	// ***************************************************************
	// Bypass and identification registers
	// ***************************************************************
	reg                  bypass_q;
	reg [`SBST_ID_W-1:0] id_q;

	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			bypass_q <= `SBST_BIT_LOW;
		end else if (upd_ir && (ir_sh_q == `SBST_IR_BYPASS)) begin
			bypass_q <= `SBST_BIT_LOW;
		end else if (cap_dr && !path_bsr && !path_id) begin
			bypass_q <= `SBST_BIT_LOW;
		end else if (shift_dr && !path_bsr && !path_id) begin
			bypass_q <= tdi_s2_q;
		end
	end

	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			id_q <= `SBST_ID_VALUE;
		end else if (cap_dr && path_id) begin
			id_q <= `SBST_ID_VALUE;
		end else if (shift_dr && path_id) begin
			id_q <= {tdi_s2_q, id_q[`SBST_ID_W-1:1]};
		end
	end

	// ***************************************************************
	// Boundary scan register
	// ***************************************************************
	wire bsr_so;

	sbst_bsr u_bsr (
		.clk_i     (SYS_CLK_I),
		.rst_i     (RESET_I),
		.tlr_i     (in_tlr),
		.capture_i (cap_dr && path_bsr),
		.shift_i   (shift_dr && path_bsr),
		.update_i  (upd_dr && path_bsr),
		.tdi_i     (tdi_s2_q),
		.ring_i    (ring_s2_q),
		.so_o      (bsr_so),
		.preload_o (RING_DRIVE_O)
	);

	// ***************************************************************
	// Serial output, driven on falling edges
	// ***************************************************************
	reg dr_bit;

	always @* begin
		dr_bit = bypass_q;
		if (path_bsr) begin
			dr_bit = bsr_so;
		end else if (path_id) begin
			dr_bit = id_q[0];
		end
	end

	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			TDO_O      <= `SBST_BIT_LOW;
			TDO_OE_N_O <= `SBST_OE_OFF;
		end else if (tck_fall) begin
			case (state_q)
				ST_SHIR: begin
					TDO_O      <= ir_sh_q[0];
					TDO_OE_N_O <= `SBST_OE_ON;
				end
				ST_SHDR: begin
					TDO_O      <= dr_bit;
					TDO_OE_N_O <= `SBST_OE_ON;
				end
				default: begin
					TDO_OE_N_O <= `SBST_OE_OFF;
				end
			endcase
		end
	end

	// ***************************************************************
	// System output control
	// ***************************************************************
	// Only these two strobes reach the memory side, and only while the
	// matching instruction is current; a TAP reset never blocks accesses.
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			EXTEST_O    <= `SBST_BIT_LOW;
			Q_BUS_HIZ_O <= `SBST_BIT_LOW;
		end else begin
			EXTEST_O    <= (ir_q == `SBST_IR_EXTEST);
			Q_BUS_HIZ_O <= (ir_q == `SBST_IR_SAMPLE_Z) ||
				((ir_q == `SBST_IR_EXTEST) && !RING_DRIVE_O[`SBST_BSR_HIZ_CELL]);
		end
	end

endmodule // sbst_tap

// [sbst_tap_properties.sv]
// Checks on the ports of the test access port top.
// Assumes TCK_I is far slower than SYS_CLK_I.
`timescale 1ns/10ps
module sbst_tap_chk (
	input wire        SYS_CLK_I,
	input wire        RESET_I,
	input wire        TCK_I,
	input wire        TMS_I,
	input wire        TDI_I,
	input wire [15:0] RING_I,
	input wire        TDO_O,
	input wire        TDO_OE_N_O,
	input wire [15:0] RING_DRIVE_O,
	input wire        EXTEST_O,
	input wire        Q_BUS_HIZ_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	reg       tck_q;
	reg [7:0] since_fall;
	reg [7:0] since_rise;
	reg [2:0] tms_cnt;
	always @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tck_q      <= 1'b0;
			since_fall <= 8'hFF;
			since_rise <= 8'hFF;
			tms_cnt    <= 3'h0;
		end else begin
			tck_q      <= TCK_I;
			since_fall <= (tck_q & ~TCK_I) ? 8'h00 : since_fall + {7'h0, since_fall != 8'hFF};
			since_rise <= (~tck_q & TCK_I) ? 8'h00 : since_rise + {7'h0, since_rise != 8'hFF};
			if (~tck_q & TCK_I)
				tms_cnt <= TMS_I ? tms_cnt + {2'h0, tms_cnt != 3'h5} : 3'h0;
		end
	end
	chk_tdo_on_fall: assert property ($changed(TDO_O) |-> since_fall <= 8'h06)
		else $error("TDO moved off a fall");
	chk_oe_on_fall: assert property ($changed(TDO_OE_N_O) |-> since_fall <= 8'h06)
		else $error("OE moved off a fall");
	chk_oe_holds: assert property ($fell(TDO_OE_N_O) |=> !TDO_OE_N_O [*6])
		else $error("OE low too short");
	chk_powerup_idle: assert property ($fell(RESET_I) |->
		TDO_OE_N_O && !EXTEST_O && RING_DRIVE_O == 16'h8000) else $error("bad reset state");
	chk_tms_reset: assert property ($rose(tms_cnt == 3'h5) |-> ##[1:8]
		TDO_OE_N_O && !EXTEST_O && !Q_BUS_HIZ_O && RING_DRIVE_O == 16'h8000)
		else $error("no reset after five");
	chk_bus_float: assert property ((EXTEST_O && !RING_DRIVE_O[15]) [*2] |-> Q_BUS_HIZ_O)
		else $error("bus not floated");
	chk_bus_drive: assert property ((EXTEST_O && RING_DRIVE_O[15]) [*2] |-> !Q_BUS_HIZ_O)
		else $error("bus not driven");
	chk_ir_on_rise: assert property ($changed(EXTEST_O) |-> since_rise <= 8'h06)
		else $error("instruction moved off a rise");
	chk_drive_on_rise: assert property ($changed(RING_DRIVE_O) |-> since_rise <= 8'h06)
		else $error("preload moved off a rise");
	cover property (EXTEST_O && Q_BUS_HIZ_O);
	cover property ($fell(TDO_OE_N_O));
	cover property ($rose(tms_cnt == 3'h5));
endmodule // sbst_tap_chk
bind sbst_tap sbst_tap_chk u_chk (.SYS_CLK_I, .RESET_I, .TCK_I, .TMS_I, .TDI_I, .RING_I, .TDO_O,
	.TDO_OE_N_O, .RING_DRIVE_O, .EXTEST_O, .Q_BUS_HIZ_O);

// [sbst_jtag_tester.sv]
// Test controller model: drives test clock, mode select and serial input.
// Assumes its tasks are called just after a falling edge of clk_i.
`timescale 1ns/10ps
module sbst_jtag_tester (
	input  wire clk_i,
	input  wire tdo_i,
	input  wire tdo_oe_n_i,
	output reg  tck_o,
	output reg  tms_o,
	output reg  tdi_o
);
	reg  tdo_last = 1'b0;
	// Released output reads as the inverse of its last driven bit
	wire tdo_line = tdo_oe_n_i ? ~tdo_last : tdo_i;
	initial begin
		tck_o    = 1'b0;
		tms_o    = 1'b1;
		tdi_o    = 1'b1;
	end
	always @(posedge clk_i)
		if (!tdo_oe_n_i)
			tdo_last <= tdo_i;
	task low_phase(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
		tms_o = tms;
		tdi_o = tdi;
		repeat (4) @(negedge clk_i);
		tdo  = tdo_line;
		oe_n = tdo_oe_n_i;
	endtask
	task high_phase();
		tck_o = 1'b1;
		repeat (4) @(negedge clk_i);
		tck_o = 1'b0;
	endtask
endmodule // sbst_jtag_tester

// [sram_boundary_scan_tap_tb.sv]
// Self-checking bench: tester model drives the port, a reference model predicts it.
// Assumes the checker is bound to the top and the tester model is compiled first.
`timescale 1ns/10ps
`include "sbst_consts.vh"
module sram_boundary_scan_tap_tb;
	localparam [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
	localparam [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
	// Starts low so the first falling edge is a real one, not time zero
	logic        sys_clk = 1'b0;
	logic        reset, tck, tms, tdi, tdo, tdo_oe_n, extest, hiz;
	logic        exp_oe_n, exp_tdo, s_tdo, s_oe_n;
	logic [15:0] ring, drive, mdrive;
	logic [31:0] seed, msr, sdat;
	logic [2:0]  mir;
	logic [2:0]  codes [8] = '{`SBST_IR_SAMPLE, `SBST_IR_EXTEST, `SBST_IR_SAMPLE_Z,
		`SBST_IR_IDCODE, `SBST_IR_BYPASS, 3'h3, 3'h5, 3'h6};
	int          st, mlen, err_total, comparisons;
	sbst_tap dut_u (.SYS_CLK_I(sys_clk), .RESET_I(reset), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
		.RING_I(ring), .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n), .RING_DRIVE_O(drive),
		.EXTEST_O(extest), .Q_BUS_HIZ_O(hiz));
	sbst_jtag_tester u_jt (.clk_i(sys_clk), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n), .tck_o(tck),
		.tms_o(tms), .tdi_o(tdi));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ************************************************
	// Reference model, one test clock period per step
	// ************************************************
	task automatic mreset();
		st       = 0;
		mir      = `SBST_IR_IDCODE;
		mdrive   = `SBST_BSR_PRESET;
		exp_oe_n = 1'b1;
	endtask
	task automatic tstep(input logic t, input logic d);
		logic bsr;
		bsr = mir == `SBST_IR_EXTEST || mir == `SBST_IR_SAMPLE_Z || mir == `SBST_IR_SAMPLE;
		void'(rnd());
		ring = seed[15:0];
		u_jt.low_phase(t, d, s_tdo, s_oe_n);
		check(s_oe_n, exp_oe_n);
		if (!exp_oe_n) check(s_tdo, exp_tdo);
		check(drive, mdrive);
		check({extest, hiz}, {mir == `SBST_IR_EXTEST, mir == `SBST_IR_SAMPLE_Z ||
			(mir == `SBST_IR_EXTEST && !mdrive[15])});
		case (st)
		3: begin
			msr  = mir == `SBST_IR_IDCODE ? `SBST_ID_VALUE : bsr ? {16'h0, ring} : 32'h0;
			mlen = mir == `SBST_IR_IDCODE ? 32 : bsr ? 16 : 1;
		end
		4, 11: begin
			msr = msr >> 1;
			msr[mlen-1] = d;
		end
		8: if (bsr) mdrive = msr[15:0];
		10: begin
			msr  = 32'h1;
			mlen = 3;
		end
		15: mir = msr[2:0];
		endcase
		st = t ? NXT1[st*4 +: 4] : NXT0[st*4 +: 4];
		if (st == 0) mreset();
		exp_oe_n = !(st == 4 || st == 11);
		exp_tdo = msr[0];
		u_jt.high_phase();
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] dat);
		tstep(1'b1, 1'b1);
		if (ir) tstep(1'b1, 1'b1);
		tstep(1'b0, 1'b1);
		tstep(1'b0, 1'b1);
		for (int i = 0; i < n; i++) tstep(i == n - 1, dat[i]);
		tstep(1'b1, 1'b1);
		tstep(1'b0, 1'b1);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		#400000;
		err_total++;
		finish_test();
	end
	initial begin
		reset       = 1'b1;
		seed        = 32'h5E66F406;
		ring        = 16'h0;
		err_total   = 0;
		comparisons = 0;
		mreset();
		repeat (3) @(negedge sys_clk);
		reset = 1'b0;
		repeat (4) @(negedge sys_clk);
		check({tdo_oe_n, extest, hiz, drive}, {3'b100, `SBST_BSR_PRESET});
		tstep(1'b0, 1'b1);
		scan(1'b0, 32, rnd());
		foreach (codes[k]) begin
			scan(1'b1, 3, {29'h0, codes[k]});
			sdat = codes[k] == `SBST_IR_EXTEST ? 32'hFFFF_FFFF : rnd();
			if (codes[k] == `SBST_IR_SAMPLE) sdat = 32'h0;
			scan(1'b0, 32, sdat);
		end
		for (int r = 0; r < 4; r++) begin
			repeat (60) tstep(^rnd(), ^rnd());
			if (r == 2) begin
				reset = 1'b1;
				mreset();
				repeat (2) @(negedge sys_clk);
				reset = 1'b0;
				repeat (3) @(negedge sys_clk);
			end
			repeat (5) tstep(1'b1, 1'b1);
			tstep(1'b0, 1'b1);
			scan(1'b0, 32, rnd());
		end
		finish_test();
	end
endmodule // sram_boundary_scan_tap_tb
